/* File: core/flash_program_erase_control.sv */
// Flash program/erase sequencer with its AHB-Lite register slave and address forming.
`timescale 1ns/100ps

// Notes on behaviour
// - A start request runs the selected operation, timed inside; start clears on completion.
// - Software can only set start; zero means nothing runs and the last finished.
// - Program and erase only start while the write-enable bit is one.
// - Error flag sets on every start attempt, improper sequence or termination.
// - Error flag zero means the last operation completed normally.
// - Standby bit one lets the flash regulator sleep during idle mode.
// - Operation code 0011 erases one memory page.
// - Operation code 0001 programs a double word; other codes are reserved.
// - Control bits 11 to 4 read zero and ignore writes.
// - Program space is 24 bits wide, data space 16 bits wide.
// - Fetch address is zero, program counter bits 22 to 1, zero.
// - Table address is page register over effective address; page bit 7 selects configuration.
// - Table accesses reach any byte or word of the 24-bit program word.
// - Mapped program space is read-only and shows only the low word.
// - Codes other than erase and double-word program start nothing.
// - Start, enable, error and operation bits reset only at power-on.
// - The power-save instruction is ignored while an operation runs.
// - Double-word program writes two adjacent words on a four-word boundary.
module flash_program_erase_control #(
  parameter int PROG_CYCLES  = flash_ctrl_pkg::PROG_CYCLES_DEF,
  parameter int ERASE_CYCLES = flash_ctrl_pkg::ERASE_CYCLES_DEF
) (
  input  wire logic                                 clk_sys,
  input  wire logic                                 rst_n,
  input  wire logic                                 softRst_n,
  input  wire logic                                 ce,
  input  wire logic                                 hsel,
  input  wire logic [31:0]                          haddr,
  input  wire logic [1:0]                           htrans,
  input  wire logic                                 hwrite,
  input  wire logic [2:0]                           hsize,
  input  wire logic [31:0]                          hwdata,
  input  wire logic                                 hready,
  output logic                                      hreadyout,
  output logic                                      hresp,
  output logic [31:0]                               hrdata,
  input  wire flash_ctrl_pkg::access_e              accKind,
  input  wire logic                                 accWrite,
  input  wire logic                                 accByte,
  input  wire logic                                 accHigh,
  input  wire logic [21:0]                          pcWord,
  input  wire logic [flash_ctrl_pkg::DATA_W-1:0]    effectiveAddress,
  output logic [flash_ctrl_pkg::PROG_ADDR_W-1:0]    progAddr,
  output logic [flash_ctrl_pkg::LANE_W-1:0]         laneEn,
  output logic                                      configSpace,
  input  wire logic                                 abortReq,
  input  wire logic                                 idleMode,
  input  wire logic                                 powerSaveReq,
  output logic                                      powerSaveAck,
  output logic                                      regulatorStandby,
  output logic                                      flashGo,
  output logic [3:0]                                flashOp,
  output logic [flash_ctrl_pkg::PROG_ADDR_W-1:0]    flashAddr,
  output logic                                      flashBusy,
  output logic                                      irq
);
  import flash_ctrl_pkg::*;

  if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << TIMER_W) ||
      ERASE_CYCLES < 1 || ERASE_CYCLES >= (1 << TIMER_W))
  begin : g_chk
    $error("flash_program_erase_control: operation time does not fit the timer");
  end

  typedef struct packed {
    logic                   startBit;
    logic                   enableBit;
    logic                   errFlag;
    logic                   standbyBit;
    logic [3:0]             opSel;
    logic [PAGE_W-1:0]      tablePage;
    logic [ST_W-1:0]        status;
    logic [ST_W-1:0]        mask;
    logic                   wrPend;
    logic                   rdPend;
    logic                   regHit;
    logic [1:0]             regIdx;
    logic [31:0]            rdData;
    logic [PROG_ADDR_W-1:0] targetAddr;
    logic [PROG_ADDR_W-1:0] goAddr;
    logic                   go;
    logic [3:0]             goOp;
    seq_e                   seq;
  } state_s;

  state_s cur_r;
  state_s cur_nxt;

  logic               timerLoad;
  logic [TIMER_W-1:0] timerVal;
  logic               timerAbort;
  logic               timerDone;
  logic               psvRefused;
  logic               startTry;
  logic               addrTaken;
  logic [3:0]         newOp;
  logic               newEnable;
  logic               opValid;
  logic [ST_W-1:0]    evt;
  logic [15:0]        ctrlView;

  // ---------------------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------------------
  op_timer #(
    .CNT_W   (TIMER_W)
  ) u_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .load    (timerLoad),
    .loadVal (timerVal),
    .abort   (timerAbort),
    .busy    (),
    .done    (timerDone)
  );

  prog_addr_former u_former (
    .clk_sys          (clk_sys),
    .rst_n            (rst_n),
    .ce               (ce),
    .accKind          (accKind),
    .accWrite         (accWrite),
    .accByte          (accByte),
    .accHigh          (accHigh),
    .pcWord           (pcWord),
    .effectiveAddress (effectiveAddress),
    .tablePage        (cur_r.tablePage),
    .progAddr         (progAddr),
    .laneEn           (laneEn),
    .configSpace      (configSpace),
    .accRefused       (psvRefused)
  );

  // ---------------------------------------------------------------------------
  // Register view and decode helpers
  // ---------------------------------------------------------------------------
  assign ctrlView = {cur_r.startBit, cur_r.enableBit, cur_r.errFlag, cur_r.standbyBit,
                     CTL_UNIMPL, cur_r.opSel};
  assign addrTaken = ce && hsel && hready && htrans[1];
  assign startTry  = ce && cur_r.wrPend && cur_r.regHit && (cur_r.regIdx == IDX_CONTROL) &&
                     hwdata[CTL_START];
  // Enable and code are frozen while running so a running operation cannot be retargeted.
  assign newOp     = cur_r.startBit ? cur_r.opSel : hwdata[CTL_OP_MSB:0];
  assign newEnable = cur_r.startBit ? cur_r.enableBit : hwdata[CTL_ENABLE];
  assign opValid   = (newOp == OP_PAGE_ERASE) || (newOp == OP_DWORD_PGM);

  // ---------------------------------------------------------------------------
  // Sequencer and registers
  // ---------------------------------------------------------------------------
  always_comb
  begin
    cur_nxt    = cur_r;
    cur_nxt.go = 1'b0;
    timerLoad  = 1'b0;
    timerAbort = 1'b0;
    timerVal   = TIMER_W'(PROG_CYCLES);
    evt        = ST_RESET;

    // Bus address phase; reads insert one wait state so they see completed writes.
    cur_nxt.wrPend = addrTaken && hwrite;
    cur_nxt.rdPend = addrTaken && !hwrite;
    if (addrTaken)
    begin
      cur_nxt.regHit = (haddr[31:ADDR_IDX_MSB+1] == '0) && (haddr[ADDR_IDX_LSB-1:0] == 2'h0);
      cur_nxt.regIdx = haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
    end
    if (cur_r.rdPend)
    begin
      cur_nxt.rdData = 32'h0000_0000;
      if (cur_r.regHit)
      begin
        case (cur_r.regIdx)
          IDX_CONTROL:    cur_nxt.rdData = {16'h0000, ctrlView};
          IDX_TABLE_PAGE: cur_nxt.rdData = {24'h00_0000, cur_r.tablePage};
          IDX_STATUS:     cur_nxt.rdData = {29'h0000_0000, cur_r.status};
          IDX_MASK:       cur_nxt.rdData = {29'h0000_0000, cur_r.mask};
          default:        cur_nxt.rdData = 32'h0000_0000;
        endcase
      end
    end

    // Software writes, applied before hardware events so that the hardware wins.
    if (cur_r.wrPend && cur_r.regHit)
    begin
      case (cur_r.regIdx)
        IDX_CONTROL:
        begin
          cur_nxt.enableBit  = newEnable;
          cur_nxt.opSel      = newOp;
          cur_nxt.errFlag    = hwdata[CTL_ERROR];
          cur_nxt.standbyBit = hwdata[CTL_STANDBY];
        end
        IDX_TABLE_PAGE: cur_nxt.tablePage = hwdata[PAGE_W-1:0];
        IDX_STATUS:     cur_nxt.status    = cur_r.status & ~hwdata[ST_W-1:0];
        IDX_MASK:       cur_nxt.mask      = hwdata[ST_W-1:0];
        default:        cur_nxt.mask      = cur_r.mask;
      endcase
    end

    // The last table write made while no operation runs names the flash location that the next operation targets.
    if (accKind == ACC_TABLE && accWrite && !cur_r.startBit)
    begin
      cur_nxt.targetAddr = {cur_r.tablePage, effectiveAddress};
    end

    case (cur_r.seq)
      SEQ_RUN:
      begin
        if (abortReq)
        begin
          cur_nxt.startBit = 1'b0;
          cur_nxt.errFlag  = 1'b1;
          cur_nxt.seq      = SEQ_IDLE;
          timerAbort       = 1'b1;
          evt[ST_SEQ_ERR]  = 1'b1;
        end
        else if (timerDone)
        begin
          cur_nxt.startBit = 1'b0;
          cur_nxt.errFlag  = 1'b0;
          cur_nxt.seq      = SEQ_IDLE;
          evt[ST_DONE]     = 1'b1;
        end
      end
      SEQ_IDLE:
      begin
        cur_nxt.seq = SEQ_IDLE;
      end
      default:
      begin
        cur_nxt.seq = SEQ_IDLE;
      end
    endcase

    if (startTry)
    begin
      cur_nxt.errFlag = 1'b1;
      if (cur_r.seq == SEQ_IDLE && newEnable && opValid)
      begin
        cur_nxt.startBit = 1'b1;
        cur_nxt.seq      = SEQ_RUN;
        cur_nxt.go       = 1'b1;
        cur_nxt.goOp     = newOp;
        cur_nxt.goAddr   = (newOp == OP_DWORD_PGM) ? (cur_r.targetAddr & DWORD_MASK)
                                                    : cur_r.targetAddr;
        timerLoad        = 1'b1;
        timerVal         = (newOp == OP_PAGE_ERASE) ? TIMER_W'(ERASE_CYCLES)
                                                    : TIMER_W'(PROG_CYCLES);
      end
      else
      begin
        evt[ST_SEQ_ERR] = 1'b1;
      end
    end

    evt[ST_PSV_REFUSED] = psvRefused;
    cur_nxt.status      = cur_nxt.status | evt;

    // Other reset sources leave start, enable, error and code untouched.
    if (!softRst_n)
    begin
      cur_nxt.standbyBit = 1'b0;
      cur_nxt.tablePage  = PAGE_RESET;
      cur_nxt.status     = ST_RESET;
      cur_nxt.mask       = ST_RESET;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cur_r            <= '0;
      cur_r.startBit   <= CTL_RESET[CTL_START];
      cur_r.enableBit  <= CTL_RESET[CTL_ENABLE];
      cur_r.errFlag    <= CTL_RESET[CTL_ERROR];
      cur_r.opSel      <= OP_RESET;
      cur_r.seq        <= SEQ_IDLE;
    end
    else if (ce)
    begin
      cur_r <= cur_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign hreadyout        = ce && !cur_r.rdPend;
  assign hresp            = 1'b0;
  assign hrdata           = cur_r.rdData;
  assign flashGo          = cur_r.go;
  assign flashOp          = cur_r.goOp;
  assign flashAddr        = cur_r.goAddr;
  assign flashBusy        = cur_r.startBit;
  assign powerSaveAck     = powerSaveReq && !cur_r.startBit;
  assign regulatorStandby = idleMode && cur_r.standbyBit;
  assign irq              = |(cur_r.status & cur_r.mask);

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_start_needs_enable: assert property ($rose(cur_r.startBit) |-> cur_r.enableBit)
    else $error("start bit rose without write enable");
  a_error_on_try: assert property (startTry |=> cur_r.errFlag)
    else $error("start attempt did not set the error flag");
  a_done_clears: assert property (ce && timerDone && !abortReq && !startTry && softRst_n
                                  |=> !cur_r.startBit && !cur_r.errFlag)
    else $error("completion did not clear start and error");
  a_start_holds: assert property (cur_r.startBit && !timerDone && !abortReq |=> cur_r.startBit)
    else $error("start bit dropped before the operation ended");
  a_reserved_idle: assert property (startTry && !opValid |=> !flashGo)
    else $error("reserved code started an operation");
  a_go_code: assert property (flashGo |-> flashOp == OP_PAGE_ERASE || flashOp == OP_DWORD_PGM)
    else $error("operation issued with an unlisted code");
  a_dword_align: assert property (flashGo && flashOp == OP_DWORD_PGM |-> flashAddr[2:0] == 3'h0)
    else $error("double word program not on a four-word boundary");
  a_psave_busy: assert property (cur_r.startBit |-> !powerSaveAck)
    else $error("power save accepted during an operation");
  a_unimpl_zero: assert property (ce && cur_r.rdPend && cur_r.regHit &&
                                  cur_r.regIdx == IDX_CONTROL |=> hrdata[11:4] == 8'h00)
    else $error("unimplemented control bits read nonzero");
  a_go_busy: assert property (flashGo && !abortReq |-> flashBusy ##1 flashBusy)
    else $error("operation ended in its first cycle");

  c_erase: cover property (flashGo && flashOp == OP_PAGE_ERASE);
  c_program: cover property (flashGo && flashOp == OP_DWORD_PGM);
  c_abort: cover property (cur_r.startBit && abortReq);
  c_psv_refused: cover property (psvRefused);

endmodule : flash_program_erase_control

/* File: core/flash_ctrl_pkg.sv */
// Shared constants, types and register layout of the flash program/erase controller.
package flash_ctrl_pkg;

  // ---------------------------------------------------------------------------
  // Register map (word indices from byte address bits 3 to 2 on the AHB-Lite slave)
  // ---------------------------------------------------------------------------
  localparam logic [1:0] IDX_CONTROL    = 2'h0;
  localparam logic [1:0] IDX_TABLE_PAGE = 2'h1;
  localparam logic [1:0] IDX_STATUS     = 2'h2;
  localparam logic [1:0] IDX_MASK       = 2'h3;
  localparam int         ADDR_IDX_LSB   = 2;
  localparam int         ADDR_IDX_MSB   = 3;

  // ---------------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------------
  localparam int          CTL_START    = 15;
  localparam int          CTL_ENABLE   = 14;
  localparam int          CTL_ERROR    = 13;
  localparam int          CTL_STANDBY  = 12;
  localparam int          CTL_OP_MSB   = 3;
  localparam logic [15:0] CTL_RESET    = 16'h0000;
  localparam logic [7:0]  CTL_UNIMPL   = 8'h00;
  localparam logic [3:0]  OP_RESET     = 4'h0;
  localparam logic [3:0]  OP_DWORD_PGM = 4'h1;
  localparam logic [3:0]  OP_PAGE_ERASE = 4'h3;

  // ---------------------------------------------------------------------------
  // Status and mask layout
  // ---------------------------------------------------------------------------
  localparam int         ST_W           = 3;
  localparam int         ST_DONE        = 0;
  localparam int         ST_SEQ_ERR     = 1;
  localparam int         ST_PSV_REFUSED = 2;
  localparam logic [2:0] ST_RESET       = 3'h0;
  localparam logic [7:0] PAGE_RESET     = 8'h00;

  // ---------------------------------------------------------------------------
  // Address spaces
  // ---------------------------------------------------------------------------
  localparam int          PROG_ADDR_W  = 24;
  localparam int          DATA_W       = 16;
  localparam int          PAGE_W       = 8;
  localparam int          LANE_W       = 3;
  localparam logic [23:0] DWORD_MASK   = 24'hFFFFF8;
  localparam logic [2:0]  LANE_ALL     = 3'h7;
  localparam logic [2:0]  LANE_LOW_W   = 3'h3;
  localparam logic [2:0]  LANE_B0      = 3'h1;
  localparam logic [2:0]  LANE_B1      = 3'h2;
  localparam logic [2:0]  LANE_HIGH    = 3'h4;
  localparam logic [2:0]  LANE_NONE    = 3'h0;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int PROG_TIME_NS   = 2000;
  localparam int ERASE_TIME_NS  = 20000;
  localparam int PROG_CYCLES_DEF  = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES_DEF = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W        = 16;

  typedef enum logic [1:0] {ACC_NONE, ACC_FETCH, ACC_TABLE, ACC_PSV} access_e;
  typedef enum logic       {SEQ_IDLE, SEQ_RUN} seq_e;

endpackage : flash_ctrl_pkg

/* File: core/op_timer.sv */
// Down-counter that times one self-timed flash operation.
`timescale 1ns/100ps
module op_timer #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] loadVal,
  input  wire logic             abort,
  output logic                  busy,
  output logic                  done
);
  import flash_ctrl_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             busy;
  } timer_s;

  timer_s cur_r;
  timer_s cur_nxt;

  if (CNT_W < 2 || CNT_W > 31)
  begin : g_chk
    $error("op_timer: CNT_W out of range");
  end

  always_comb
  begin
    cur_nxt = cur_r;
    if (abort)
    begin
      cur_nxt.busy = 1'b0;
    end
    else if (load)
    begin
      cur_nxt.cnt  = loadVal - {{(CNT_W-1){1'b0}}, 1'b1};
      cur_nxt.busy = 1'b1;
    end
    else if (cur_r.busy)
    begin
      if (cur_r.cnt == '0)
      begin
        cur_nxt.busy = 1'b0;
      end
      else
      begin
        cur_nxt.cnt = cur_r.cnt - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cur_r <= '0;
    end
    else if (ce)
    begin
      cur_r <= cur_nxt;
    end
  end

  assign busy = cur_r.busy;
  // The operation ends after exactly loadVal cycles of running.
  assign done = cur_r.busy && (cur_r.cnt == '0) && !abort;

endmodule : op_timer

/* File: core/prog_addr_former.sv */
// Forms program-space addresses and byte lanes for fetch, table and read-only mapped access.
`timescale 1ns/100ps
module prog_addr_former (
  input  wire logic                                 clk_sys,
  input  wire logic                                 rst_n,
  input  wire logic                                 ce,
  input  wire flash_ctrl_pkg::access_e              accKind,
  input  wire logic                                 accWrite,
  input  wire logic                                 accByte,
  input  wire logic                                 accHigh,
  input  wire logic [21:0]                          pcWord,
  input  wire logic [flash_ctrl_pkg::DATA_W-1:0]    effectiveAddress,
  input  wire logic [flash_ctrl_pkg::PAGE_W-1:0]    tablePage,
  output logic [flash_ctrl_pkg::PROG_ADDR_W-1:0]    progAddr,
  output logic [flash_ctrl_pkg::LANE_W-1:0]         laneEn,
  output logic                                      configSpace,
  output logic                                      accRefused
);
  import flash_ctrl_pkg::*;

  typedef struct packed {
    logic [PROG_ADDR_W-1:0] addr;
    logic [LANE_W-1:0]      lane;
    logic                   cfg;
    logic                   refused;
  } former_s;

  former_s cur_r;
  former_s cur_nxt;

  always_comb
  begin
    cur_nxt         = cur_r;
    cur_nxt.refused = 1'b0;
    case (accKind)
      ACC_FETCH:
      begin
        cur_nxt.addr = {1'b0, pcWord, 1'b0};
        cur_nxt.lane = LANE_ALL;
        cur_nxt.cfg  = 1'b0;
      end
      ACC_TABLE:
      begin
        cur_nxt.addr = {tablePage, effectiveAddress};
        cur_nxt.cfg  = tablePage[PAGE_W-1];
        if (accHigh)
        begin
          cur_nxt.lane = LANE_HIGH;
        end
        else if (accByte)
        begin
          cur_nxt.lane = effectiveAddress[0] ? LANE_B1 : LANE_B0;
        end
        else
        begin
          cur_nxt.lane = LANE_LOW_W;
        end
      end
      ACC_PSV:
      begin
        cur_nxt.addr = {1'b0, tablePage[PAGE_W-2:0], effectiveAddress};
        cur_nxt.cfg  = 1'b0;
        if (accWrite)
        begin
          cur_nxt.lane    = LANE_NONE;
          cur_nxt.refused = 1'b1;
        end
        else if (accByte)
        begin
          cur_nxt.lane = effectiveAddress[0] ? LANE_B1 : LANE_B0;
        end
        else
        begin
          cur_nxt.lane = LANE_LOW_W;
        end
      end
      default:
      begin
        cur_nxt.lane = LANE_NONE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cur_r <= '0;
    end
    else if (ce)
    begin
      cur_r <= cur_nxt;
    end
  end

  assign progAddr    = cur_r.addr;
  assign laneEn      = cur_r.lane;
  assign configSpace = cur_r.cfg;
  assign accRefused  = cur_r.refused;

endmodule : prog_addr_former

/* File: bench/core_model.sv */
// Processor core model that issues program-space access requests.
`timescale 1ns/100ps
module core_model
  import flash_ctrl_pkg::*;
(
  input  wire logic        clk_sys,
  output access_e          accKind,
  output logic             accWrite,
  output logic [21:0]      pcWord,
  output logic [15:0]      effectiveAddress,
  output logic             accByte,
  output logic             accHigh
);
  initial
  begin
    accKind = ACC_NONE;
    accWrite = 1'b0;
    pcWord = 22'h000000;
    effectiveAddress = 16'h0000;
    accByte = 1'b0;
    accHigh = 1'b0;
  end

  // Requests change just after an edge and stand for one cycle only.
  task automatic acc(input access_e k, input logic w, input logic [21:0] pc,
                     input logic [15:0] ea, input logic [1:0] bh);
    @(posedge clk_sys);
    accKind <= k;
    accByte <= bh[0];
    accHigh <= bh[1];
    accWrite <= w;
    pcWord <= pc;
    effectiveAddress <= ea;
    @(posedge clk_sys);
    accKind <= ACC_NONE;
    accByte <= 1'b0;
    accHigh <= 1'b0;
    effectiveAddress <= ~ea;
  endtask : acc
endmodule : core_model

/* File: bench/flash_program_erase_control_tb.sv */
// Register and operation tests of the flash program/erase controller.
`timescale 1ns/100ps
module flash_program_erase_control_tb;
  import flash_ctrl_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, hwrite = 1'b0, idleMode = 1'b0, powerSaveReq = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, powerSaveAck, regulatorStandby, flashGo, flashBusy, irq, configSpace;
  logic [3:0] flashOp;
  logic [23:0] progAddr, flashAddr;
  logic [2:0] laneEn;
  access_e accKind;
  logic accWrite;
  logic [21:0] pcWord;
  logic [15:0] effectiveAddress;
  logic accByte, accHigh, softRst_n = 1'b1, abortReq = 1'b0;
  int errors = 0, n_tests = 0, n;
  core_model u_core (.clk_sys(clk_sys), .accKind(accKind), .accWrite(accWrite),
    .pcWord(pcWord), .effectiveAddress(effectiveAddress), .accByte(accByte),
    .accHigh(accHigh));
  flash_program_erase_control #(.PROG_CYCLES(8), .ERASE_CYCLES(20)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .softRst_n(softRst_n), .ce(1'b1), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .accKind(accKind), .accWrite(accWrite), .accByte(accByte), .accHigh(accHigh),
    .pcWord(pcWord), .effectiveAddress(effectiveAddress), .progAddr(progAddr),
    .laneEn(laneEn), .configSpace(configSpace), .abortReq(abortReq), .idleMode(idleMode),
    .powerSaveReq(powerSaveReq), .powerSaveAck(powerSaveAck),
    .regulatorStandby(regulatorStandby), .flashGo(flashGo), .flashOp(flashOp),
    .flashAddr(flashAddr), .flashBusy(flashBusy), .irq(irq));
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end
  // ---------------------------------------------------------------------------
  // Bus, check and end-of-run tasks
  // ---------------------------------------------------------------------------
  task automatic complete_run();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // The bound is generous; a hung slave counts a mismatch and ends the run.
  task automatic rdy();
    int i;
    i = 0;
    do
    begin
      @(posedge clk_sys);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 50);
    if (i >= 50)
    begin
      errors++;
      complete_run();
    end
  endtask : rdy
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= v;
    rdy();
  endtask : wr
  task automatic rd(input logic [31:0] a);
    haddr <= a;
    hwrite <= 1'b0;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    rdy();
    d = hrdata;
  endtask : rd
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(32'h0); chk("ctl reset", 32'h0, d);
    wr(32'h4, 32'h85);
    u_core.acc(ACC_TABLE, 1'b1, 22'h0, 16'h1235, 2'b00);
    @(posedge clk_sys); chk("tbl addr", 32'h851235, progAddr);
    chk("cfg space", 32'h1, configSpace);
    u_core.acc(ACC_TABLE, 1'b0, 22'h0, 16'h1237, 2'b01);
    @(posedge clk_sys); chk("byte lane", LANE_B1, laneEn);
    u_core.acc(ACC_TABLE, 1'b0, 22'h0, 16'h1234, 2'b10);
    @(posedge clk_sys); chk("high lane", LANE_HIGH, laneEn);
    u_core.acc(ACC_FETCH, 1'b0, 22'h2AAAAA, 16'h0, 2'b00);
    @(posedge clk_sys); chk("fetch addr", 32'h555554, progAddr);
    chk("fetch lanes", LANE_ALL, laneEn);
    powerSaveReq <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      wr(32'h0, 32'hCFF0 | (i ? 32'h3 : 32'h1));
      n = 0;
      repeat (2) @(posedge clk_sys) n += (flashBusy === 1'b1);
      chk("ps ack", 32'h0, powerSaveAck);
      repeat (30) @(posedge clk_sys) n += (flashBusy === 1'b1);
      chk("busy len", i ? 20 : 8, n);
      chk("op", i ? 32'h3 : 32'h1, flashOp);
      chk("addr", i ? 32'h851235 : 32'h851230, flashAddr);
      rd(32'h0); chk("ctl done", i ? 32'h4003 : 32'h4001, d);
    end
    chk("ps idle", 32'h1, powerSaveAck);
    wr(32'h0, 32'hC003);
    repeat (3) @(posedge clk_sys);
    abortReq <= 1'b1;
    @(posedge clk_sys);
    abortReq <= 1'b0;
    rd(32'h0); chk("abort", 32'h6003, d);
    wr(32'h0, 32'hC002); rd(32'h0); chk("reserved", 32'h6002, d);
    wr(32'h0, 32'h8003); rd(32'h0); chk("inhibit", 32'h2003, d);
    u_core.acc(ACC_PSV, 1'b1, 22'h0, 16'h0010, 2'b00);
    @(posedge clk_sys); chk("psv lanes", LANE_NONE, laneEn);
    rd(32'h8); chk("status", 32'h7, d);
    wr(32'hC, 32'h4);
    @(posedge clk_sys); chk("irq on", 32'h1, irq);
    wr(32'h8, 32'h7); @(posedge clk_sys); chk("irq off", 32'h0, irq);
    rd(32'h10); chk("unmapped", 32'h0, d);
    idleMode <= 1'b1;
    @(posedge clk_sys); chk("awake", 32'h0, regulatorStandby);
    wr(32'h0, 32'h7003);
    @(posedge clk_sys); chk("standby", 32'h1, regulatorStandby);
    softRst_n <= 1'b0;
    @(posedge clk_sys);
    softRst_n <= 1'b1;
    rd(32'h0); chk("soft ctl", 32'h6003, d);
    rd(32'h4); chk("soft page", 32'h0, d);
    complete_run();
  end
endmodule : flash_program_erase_control_tb
